// ### adc_input_select_buffering.sv
// Channel and reference selection buffering with Avalon-MM registers
//
// How it works
// R01 - Holding register keeps 5-bit channel and 2-bit reference, always readable and writable
// R02 - With no conversion running, active selection copies holding register every clock
// R03 - Once a conversion starts, active selection is frozen against holding changes
// R04 - Lock is released in the final conversion clock, before done flag sets
// R05 - Start bit written: conversion and lock begin on the next rising edge
// R06 - Software should wait one clock after start before new selection writes
// R07 - With auto trigger and enable on, selection changes are unpredictable
// R08 - Changing selection is safe one clock after the trigger that started conversion
// R09 - Changing selection is safe after completion, before the trigger flag clears
// R10 - A selection written safely applies to the next conversion, not the current
`include "adc_sel_defines.svh"

module adc_input_select_buffering #(
   parameter int NORMAL_CYCLES = `CONV_NORMAL,
   parameter int FIRST_CYCLES  = `CONV_FIRST
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rstn_i,
   input  wire logic        ce_i,
   input  wire logic [4:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   input  wire logic [3:0]  byteenable_i,
   output logic [31:0]      readdata_o,
   output logic             waitrequest_o,
   input  wire logic        trigger_i,
   output logic [4:0]       channel_select_o,
   output logic [1:0]       reference_select_o,
   output logic             conv_busy_o,
   output logic             irq_o
);
   logic [4:0]         hold_ch_r;
   logic [1:0]         hold_ref_r;
   logic [4:0]         act_ch_r;
   logic [1:0]         act_ref_r;
   logic               converter_enable_r;
   logic               auto_trigger_enable_r;
   logic               start_req_r;
   adc_sel_pkg::evt_t  status_r;
   adc_sel_pkg::evt_t  mask_r;
   logic               wait_r;
   logic [31:0]        rdata_r;
   logic               irq_r;
   logic               trig_s1_r;
   logic               trig_s2_r;
   logic               trig_s3_r;
   logic               trig_lvl_r;
   logic               trig_edge;
   logic               seq_busy;
   logic               seq_last;
   logic               lock;
   logic               wr_en;
   logic               start_wr;
   logic [31:0]        rdata_nxt;
   adc_sel_pkg::evt_t  evt_set;

   // Register hit with byte lane 0 written
   function automatic logic hit(input logic [4:0] a, input logic [4:0] off, input logic [3:0] be);
      hit = (a == off) && be[0];
   endfunction

   // ----------------------------------------------------------------
   // Avalon-MM handshake: one wait cycle, write applies as wait drops
   // ----------------------------------------------------------------
   assign wr_en = write_i && !wait_r && ce_i;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else if (ce_i) begin
         wait_r  <= !((read_i || write_i) && wait_r);
         rdata_r <= rdata_nxt;
      end
   end

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (address_i)
         `OFF_SEL: begin
            rdata_nxt[`CH_MSB:`CH_LSB]   = hold_ch_r;  // R01
            rdata_nxt[`REF_MSB:`REF_LSB] = hold_ref_r;
         end
         `OFF_CTRL: begin
            rdata_nxt[`CTRL_EN]    = converter_enable_r;
            rdata_nxt[`CTRL_AUTO]  = auto_trigger_enable_r;
            rdata_nxt[`CTRL_START] = seq_busy || start_req_r;
         end
         `OFF_STAT: begin
            rdata_nxt[1:0] = status_r;
         end
         `OFF_MASK: begin
            rdata_nxt[1:0] = mask_r;
         end
         `OFF_ACT: begin
            rdata_nxt[`CH_MSB:`CH_LSB]   = act_ch_r;
            rdata_nxt[`REF_MSB:`REF_LSB] = act_ref_r;
            rdata_nxt[`ACT_LOCK]         = lock;
         end
         default: begin
            rdata_nxt = 32'h0000_0000;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Holding register, writable at any time
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hold_ch_r  <= `CH_RST;
         hold_ref_r <= `REF_RST;
      end else if (wr_en && hit(address_i, `OFF_SEL, byteenable_i)) begin
         hold_ch_r  <= writedata_i[`CH_MSB:`CH_LSB];  // R01
         hold_ref_r <= writedata_i[`REF_MSB:`REF_LSB];
      end
   end

   // ----------------------------------------------------------------
   // Control and mask registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         converter_enable_r    <= 1'b0;
         auto_trigger_enable_r <= 1'b0;
         mask_r                <= `EVT_RST;
      end else if (wr_en) begin
         if (hit(address_i, `OFF_CTRL, byteenable_i)) begin
            converter_enable_r    <= writedata_i[`CTRL_EN];
            auto_trigger_enable_r <= writedata_i[`CTRL_AUTO];
         end
         if (hit(address_i, `OFF_MASK, byteenable_i)) begin
            mask_r <= writedata_i[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Trigger pin: three-stage synchroniser, change once stages 2 and 3 agree
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         trig_s1_r  <= 1'b0;
         trig_s2_r  <= 1'b0;
         trig_s3_r  <= 1'b0;
         trig_lvl_r <= 1'b0;
      end else if (ce_i) begin
         trig_s1_r <= trigger_i;
         trig_s2_r <= trig_s1_r;
         trig_s3_r <= trig_s2_r;
         if (trig_s2_r == trig_s3_r) begin
            trig_lvl_r <= trig_s3_r;
         end
      end
   end

   assign trig_edge = (trig_s2_r == trig_s3_r) && trig_s3_r && !trig_lvl_r;

   // ----------------------------------------------------------------
   // Start request: taken at the write edge, conversion on the next edge
   // ----------------------------------------------------------------
   assign start_wr = wr_en && hit(address_i, `OFF_CTRL, byteenable_i) && writedata_i[`CTRL_START];

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         start_req_r <= 1'b0;
      end else if (ce_i) begin
         start_req_r <= converter_enable_r && !seq_busy && !start_req_r &&
                        (start_wr || (auto_trigger_enable_r && trig_edge));  // R05
      end
   end

   conv_sequencer #(
      .NORMAL_CYCLES (NORMAL_CYCLES),
      .FIRST_CYCLES  (FIRST_CYCLES)
   ) u_seq (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .ce_i      (ce_i),
      .enable_i  (converter_enable_r),
      .start_i   (start_req_r),  // R05
      .busy_o    (seq_busy),
      .last_o    (seq_last)
   );

   // ----------------------------------------------------------------
   // Active selection: follows holding unless locked
   // ----------------------------------------------------------------
   assign lock = seq_busy && !seq_last;  // R03 R04

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         act_ch_r  <= `CH_RST;
         act_ref_r <= `REF_RST;
      end else if (ce_i && !lock) begin
         act_ch_r  <= hold_ch_r;  // R02 R10
         act_ref_r <= hold_ref_r;
      end
   end

   // ----------------------------------------------------------------
   // Sticky events, write one to clear, set wins
   // ----------------------------------------------------------------
   assign evt_set = {start_req_r, seq_last};

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         status_r <= `EVT_RST;
         irq_r    <= 1'b0;
      end else if (ce_i) begin
         if (wr_en && hit(address_i, `OFF_STAT, byteenable_i)) begin
            status_r <= (status_r & ~writedata_i[1:0]) | evt_set;
         end else begin
            status_r <= status_r | evt_set;
         end
         irq_r <= |(status_r & mask_r);
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign readdata_o         = rdata_r;
   assign waitrequest_o      = wait_r;
   assign channel_select_o   = act_ch_r;
   assign reference_select_o = act_ref_r;
   assign conv_busy_o        = seq_busy;
   assign irq_o              = irq_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);

   a_hold_write: assert property (  // R01
      (wr_en && hit(address_i, `OFF_SEL, byteenable_i)) |=>
      (hold_ch_r == $past(writedata_i[4:0])) && (hold_ref_r == $past(writedata_i[7:6])))
      else $error("holding register missed a write");

   a_copy_idle: assert property (  // R02
      (ce_i && !seq_busy) |=> (act_ch_r == $past(hold_ch_r)) && (act_ref_r == $past(hold_ref_r)))
      else $error("active selection not following holding while idle");

   a_freeze_conv: assert property (  // R03
      (ce_i && seq_busy && !seq_last) |=> $stable(act_ch_r) && $stable(act_ref_r))
      else $error("active selection changed while locked");

   a_release_last: assert property (  // R04
      (ce_i && seq_last) |=> !seq_busy && status_r[`ST_DONE] && (act_ch_r == $past(hold_ch_r)))
      else $error("lock not released in final cycle");

   a_start_next: assert property (  // R05
      (start_wr && converter_enable_r && !seq_busy && !start_req_r) |=>
      start_req_r ##1 (seq_busy || !$past(ce_i)))
      else $error("conversion did not start on the next edge");

   a_next_conv: assert property (  // R10
      $rose(seq_busy) |-> (act_ch_r == $past(hold_ch_r)) && (act_ref_r == $past(hold_ref_r)))
      else $error("conversion started with stale selection");

   c_manual_conv: cover property (start_wr ##[1:40] seq_last);
   c_auto_conv: cover property (auto_trigger_enable_r && trig_edge ##[1:3] $rose(seq_busy));
   c_write_locked: cover property (lock && wr_en && hit(address_i, `OFF_SEL, byteenable_i));
   c_irq: cover property ($rose(irq_r));
endmodule // adc_input_select_buffering

// ### adc_sel_defines.svh
// Register offsets, field positions, reset values and cycle counts
`ifndef ADC_SEL_DEFINES_SVH
`define ADC_SEL_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_SEL      5'h00
`define OFF_CTRL     5'h04
`define OFF_STAT     5'h08
`define OFF_MASK     5'h0C
`define OFF_ACT      5'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CH_LSB       0
`define CH_MSB       4
`define REF_LSB      6
`define REF_MSB      7
`define CTRL_EN      0
`define CTRL_AUTO    1
`define CTRL_START   2
`define ST_DONE      0
`define ST_START     1
`define ACT_LOCK     8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CH_RST       5'h00
`define REF_RST      2'h0
`define EVT_RST      2'h0

// ----------------------------------------------------------------
// Conversion lengths in converter clocks
// ----------------------------------------------------------------
`define CONV_NORMAL  13
`define CONV_FIRST   25

`endif

// ### adc_sel_pkg.sv
// Types shared by the input selection buffering design
package adc_sel_pkg;
   typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_t;
   typedef logic [1:0] evt_t;
endpackage

// ### conv_sequencer.sv
// Conversion cycle counter: busy span and final-cycle marker
`include "adc_sel_defines.svh"
module conv_sequencer #(
   parameter int NORMAL_CYCLES = `CONV_NORMAL,
   parameter int FIRST_CYCLES  = `CONV_FIRST
) (
   input  wire logic clk_sys_i,
   input  wire logic rstn_i,
   input  wire logic ce_i,
   input  wire logic enable_i,
   input  wire logic start_i,
   output logic      busy_o,
   output logic      last_o
);
   adc_sel_pkg::conv_state_t state_r;
   logic [5:0]               cnt_r;
   logic                     first_r;

   assign busy_o = (state_r == adc_sel_pkg::CONV_RUN);
   assign last_o = busy_o && (cnt_r == 6'h01);

   // ----------------------------------------------------------------
   // First conversion after enable runs longer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         first_r <= 1'b1;
      end else if (ce_i) begin
         if (!enable_i) begin
            first_r <= 1'b1;
         end else if (start_i) begin
            first_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Cycle counter
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r <= adc_sel_pkg::CONV_IDLE;
         cnt_r   <= 6'h00;
      end else if (ce_i) begin
         case (state_r)
            adc_sel_pkg::CONV_IDLE: begin
               if (start_i) begin
                  state_r <= adc_sel_pkg::CONV_RUN;
                  cnt_r   <= first_r ? 6'(FIRST_CYCLES) : 6'(NORMAL_CYCLES);
               end
            end
            adc_sel_pkg::CONV_RUN: begin
               if (cnt_r == 6'h01) begin
                  state_r <= adc_sel_pkg::CONV_IDLE;
               end
               cnt_r <= cnt_r - 6'h01;
            end
            default: begin
               state_r <= adc_sel_pkg::CONV_IDLE;
            end
         endcase
      end
   end
endmodule // conv_sequencer

// ### test_adc_input_select_buffering.sv
// Self-checking bench for the input selection buffering block
`include "adc_sel_defines.svh"
module test_adc_input_select_buffering;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Signals and instance
   // ----------------------------------------------------------------
   localparam int NORM = 13;
   localparam int FIRST = 25;
   logic        clk_sys_i, rstn_i, ce_i, read_i, write_i, trigger_i;
   logic [4:0]  address_i;
   logic [31:0] writedata_i;
   logic [3:0]  byteenable_i;
   logic [31:0] readdata_o;
   logic        waitrequest_o, conv_busy_o, irq_o;
   logic [4:0]  channel_select_o;
   logic [1:0]  reference_select_o;
   int          errors, checks_done, cyc, stall_n;
   logic [31:0] seed, rd;
   adc_input_select_buffering #(.NORMAL_CYCLES(NORM), .FIRST_CYCLES(FIRST)) adc_input_select_buffering_inst (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i), .address_i(address_i), .read_i(read_i),
      .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
      .waitrequest_o(waitrequest_o), .trigger_i(trigger_i), .channel_select_o(channel_select_o),
      .reference_select_o(reference_select_o), .conv_busy_o(conv_busy_o), .irq_o(irq_o));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [31:0] sel_exp(input logic [7:0] v);
      return {24'h000000, v & 8'hDF};
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic bus_write(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge clk_sys_i);
      address_i <= a;
      writedata_i <= d;
      byteenable_i <= be;
      write_i <= 1'b1;
      do @(posedge clk_sys_i); while (waitrequest_o !== 1'b0);
      write_i <= 1'b0;
   endtask
   task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk_sys_i);
      address_i <= a;
      read_i <= 1'b1;
      do @(posedge clk_sys_i); while (waitrequest_o !== 1'b0);
      d = readdata_o;
      read_i <= 1'b0;
   endtask
   // Runs one conversion with selection a, then writes b during it
   task automatic conv_check(input int n_exp, input logic use_trig);
      logic [7:0] a, b;
      int n;
      seed = xs(seed);
      a = seed[7:0] & 8'hDF;
      b = a ^ 8'hDF;
      bus_write(`OFF_SEL, {24'h0, a}, 4'hF);
      if (use_trig) begin
         @(posedge clk_sys_i) trigger_i <= 1'b1;
         repeat (3) @(posedge clk_sys_i);
         trigger_i <= 1'b0;
         n = 0;
         while (conv_busy_o !== 1'b1 && n < 20) begin
            @(negedge clk_sys_i);
            n++;
         end
      end else begin
         bus_write(`OFF_CTRL, 32'h5, 4'hF);
         @(negedge clk_sys_i);
         check("busy before start edge", conv_busy_o, 0);
         @(negedge clk_sys_i);
      end
      check("busy after start", conv_busy_o, 1);
      n = 0;
      fork
         begin
            @(posedge clk_sys_i);
            bus_write(`OFF_SEL, {24'h0, b}, 4'hF);
         end
         while (conv_busy_o === 1'b1 && n < 40) begin
            check("locked channel", channel_select_o, a[4:0]);
            check("locked reference", reference_select_o, a[7:6]);
            n++;
            @(negedge clk_sys_i);
         end
      join
      check("busy length", n, n_exp);
      check("channel after end", channel_select_o, b[4:0]);
      check("reference after end", reference_select_o, b[7:6]);
      bus_read(`OFF_ACT, rd);
      check("active readback", rd, sel_exp(b));
   endtask
   // ----------------------------------------------------------------
   // Timeout
   // ----------------------------------------------------------------
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc >= 20000) begin
         errors++;
         finish_test;
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      errors = 0;
      checks_done = 0;
      cyc = 0;
      seed = 32'hC0E5;
      rstn_i = 1'b0;
      ce_i = 1'b1;
      read_i = 1'b0;
      write_i = 1'b0;
      trigger_i = 1'b0;
      address_i = 5'h00;
      writedata_i = 32'h0;
      byteenable_i = 4'hF;
      repeat (5) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      @(negedge clk_sys_i);
      check("reset channel", channel_select_o, 0);
      check("reset busy", conv_busy_o, 0);
      check("reset irq", irq_o, 0);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         bus_write(`OFF_SEL, seed, 4'hF);
         bus_read(`OFF_SEL, rd);
         check("holding readback", rd, sel_exp(seed[7:0]));
         repeat (2) @(negedge clk_sys_i);
         check("idle channel copy", channel_select_o, seed[4:0]);
         check("idle reference copy", reference_select_o, seed[7:6]);
      end
      bus_write(`OFF_SEL, ~seed, 4'hE);
      bus_read(`OFF_SEL, rd);
      check("byte disabled write", rd, sel_exp(seed[7:0]));
      bus_read(5'h14, rd);
      check("unmapped read", rd, 0);
      bus_write(`OFF_CTRL, 32'h1, 4'hF);
      conv_check(FIRST, 1'b0);
      bus_read(`OFF_STAT, rd);
      check("status events", rd, 32'h3);
      check("masked irq", irq_o, 0);
      bus_write(`OFF_MASK, 32'h1, 4'hF);
      repeat (3) @(negedge clk_sys_i);
      check("unmasked irq", irq_o, 1);
      bus_write(`OFF_STAT, 32'h3, 4'hF);
      repeat (3) @(negedge clk_sys_i);
      check("cleared irq", irq_o, 0);
      bus_read(`OFF_STAT, rd);
      check("status cleared", rd, 0);
      for (int i = 0; i < 3; i++) conv_check(NORM, 1'b0);
      // Clock enable low for 6 cycles mid-conversion stretches busy by 6
      bus_write(`OFF_CTRL, 32'h5, 4'hF);
      stall_n = 0;
      fork
         begin
            repeat (4) @(posedge clk_sys_i);
            ce_i <= 1'b0;
            repeat (6) @(posedge clk_sys_i);
            ce_i <= 1'b1;
         end
         begin
            repeat (2) @(negedge clk_sys_i);
            while (conv_busy_o === 1'b1 && stall_n < 60) begin
               stall_n++;
               @(negedge clk_sys_i);
            end
         end
      join
      check("stalled busy length", stall_n, NORM + 6);
      bus_write(`OFF_CTRL, 32'h3, 4'hF);
      for (int i = 0; i < 3; i++) conv_check(NORM, 1'b1);
      // Auto trigger off again: selection follows at once
      bus_write(`OFF_CTRL, 32'h1, 4'hF);
      seed = xs(seed);
      bus_write(`OFF_SEL, seed, 4'hF);
      repeat (2) @(negedge clk_sys_i);
      check("follow after auto off", channel_select_o, seed[4:0]);
      bus_read(`OFF_CTRL, rd);
      check("control readback", rd, 32'h1);
      // Start while disabled is ignored
      bus_write(`OFF_CTRL, 32'h0, 4'hF);
      bus_write(`OFF_CTRL, 32'h4, 4'hF);
      repeat (30) begin
         @(negedge clk_sys_i);
         check("no start when disabled", conv_busy_o, 0);
      end
      finish_test;
   end
endmodule // test_adc_input_select_buffering
